// *** serial0_pkg.sv ***
package serial0_pkg;

  // Register addresses on the plain register port
  localparam logic [7:0] ADDR_STATUS_DETECT = 8'h0d;
  localparam logic [7:0] ADDR_CONTROL = 8'h20;
  localparam logic [7:0] ADDR_SHIFT_DATA = 8'h21;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h22;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h23;

  // Control register fields
  localparam int CTRL_I2C_MODE_BIT = 0;
  localparam int CTRL_TRANSMIT_BIT = 1;
  localparam int CTRL_WAIT_RELEASE_BIT = 2;

  // Interrupt status and mask fields
  localparam int IRQ_START_BIT = 0;
  localparam int IRQ_STOP_BIT = 1;
  localparam int IRQ_EIGHT_BIT = 2;
  localparam int IRQ_NINE_BIT = 3;

  // Reset values
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [2:0] CONTROL_RESET = 3'h0;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [1:0] PIN_IDLE = 2'h3;

  // Clock counter values
  localparam logic [3:0] COUNT_START = 4'h0;
  localparam logic [3:0] COUNT_EIGHT = 4'h8;
  localparam logic [3:0] COUNT_NINE = 4'h9;

  // Pin levels, bit 1 is the clock pin, bit 0 the data pin
  typedef struct packed {
    logic scl;
    logic sda;
  } pins_type;

  // Status detection register layout
  typedef struct packed {
    logic count_eight_flag;
    logic count_nine_flag;
    logic start_seen_flag;
    logic bus_busy_flag;
  } status_type;

  // Transfer state
  typedef enum logic [0:0] {
    XFER_IDLE = 1'b0,
    XFER_ACTIVE = 1'b1
  } xfer_state_type;

endpackage

// *** pin_sync3.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; the output moves only once stages two and three agree
module pin_sync3
  import serial0_pkg::*;
(
  input wire logic ref_clk, // Block clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire serial0_pkg::pins_type pin_in, // Raw pin levels
  output serial0_pkg::pins_type pin_out // Filtered pin levels
);

  pins_type stage1_reg;
  pins_type stage2_reg;
  pins_type stage3_reg;
  pins_type out_reg;

  // Idle bus levels at reset so no false edge appears on release
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1_reg <= PIN_IDLE;
      stage2_reg <= PIN_IDLE;
      stage3_reg <= PIN_IDLE;
    end
    else
    begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Each bit follows only when the two late stages agree, rejecting a one-cycle glitch
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      out_reg <= PIN_IDLE;
    else
    begin
      if (stage2_reg.scl == stage3_reg.scl)
        out_reg.scl <= stage3_reg.scl;
      if (stage2_reg.sda == stage3_reg.sda)
        out_reg.sda <= stage3_reg.sda;
    end
  end

  assign pin_out = out_reg;

endmodule

// *** cond_detect.sv ***
`timescale 1ns/1ps
// Edge and start/stop condition finder on filtered pin levels
module cond_detect
  import serial0_pkg::*;
(
  input wire logic ref_clk, // Block clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire serial0_pkg::pins_type pins, // Filtered pin levels
  input wire logic i2c_mode, // Start/stop detection allowed only in two-wire mode; clock edges are found in both modes
  output logic scl_rise, // One-cycle pulse on clock rising edge
  output logic scl_fall, // One-cycle pulse on clock falling edge
  output logic start_evt, // One-cycle pulse on start condition
  output logic stop_evt // One-cycle pulse on stop condition
);

  pins_type prev_reg;

  // Previous levels for edge finding
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      prev_reg <= PIN_IDLE;
    else
      prev_reg <= pins;
  end

  // Data moving while the clock stays high marks a condition
  assign scl_rise = pins.scl & ~prev_reg.scl;
  assign scl_fall = ~pins.scl & prev_reg.scl;
  assign start_evt = i2c_mode & pins.scl & prev_reg.scl & prev_reg.sda & ~pins.sda;
  assign stop_evt = i2c_mode & pins.scl & prev_reg.scl & ~prev_reg.sda & pins.sda;

endmodule

// *** serial_clock_counter_and_shifter.sv ***
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module serial_clock_counter_and_shifter
  import serial0_pkg::*;
(
  input wire logic ref_clk, // Block clock, 10 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, valid the cycle after the strobe
  input wire serial0_pkg::pins_type pin_in, // Clock and data pin levels
  output logic sda_out, // Data pin output level
  output logic sda_oe, // Data pin output enable, high while driving
  output logic irq // Level interrupt
);

  pins_type pins_s;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic i2c_mode_reg;
  logic transmit_reg;
  xfer_state_type xfer_reg;
  xfer_state_type xfer_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] count_last;
  status_type status_reg;
  status_type status_view;
  logic [7:0] shift_reg;
  logic sda_out_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_events;
  logic [7:0] rdata_reg;
  logic load_shift;

  // Address match used by both the write and read paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // Pins cross into the block clock; the clock pin itself is sampled here
  pin_sync3 u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(pin_in),
    .pin_out(pins_s)
  );

  cond_detect u_cond (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pins(pins_s),
    .i2c_mode(i2c_mode_reg),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_evt(start_evt),
    .stop_evt(stop_evt)
  );

  // Control register writes
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      i2c_mode_reg <= CONTROL_RESET[CTRL_I2C_MODE_BIT];
      transmit_reg <= CONTROL_RESET[CTRL_TRANSMIT_BIT];
    end
    else if (reg_wr && hit(reg_addr, ADDR_CONTROL))
    begin
      i2c_mode_reg <= reg_wdata[CTRL_I2C_MODE_BIT];
      transmit_reg <= reg_wdata[CTRL_TRANSMIT_BIT];
    end
  end

  // Counter wraps after its last count; bus mode adds the ninth acknowledge clock
  assign count_last = i2c_mode_reg ? COUNT_NINE : COUNT_EIGHT;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (start_evt)
      cnt_next = COUNT_START;
    else if (scl_rise)
    begin
      if (cnt_reg >= count_last)
        cnt_next = COUNT_START + 4'h1;
      else
        cnt_next = cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_reg <= COUNT_START;
    else
      cnt_reg <= cnt_next;
  end

  // Transfer runs from the wait release write to the last count of the byte
  always_comb
  begin
    xfer_next = xfer_reg;
    case (xfer_reg)
      XFER_IDLE:
        if (reg_wr && hit(reg_addr, ADDR_CONTROL) && reg_wdata[CTRL_WAIT_RELEASE_BIT])
          xfer_next = XFER_ACTIVE;
      XFER_ACTIVE:
        if (reg_wr && hit(reg_addr, ADDR_CONTROL) && !reg_wdata[CTRL_WAIT_RELEASE_BIT])
          xfer_next = XFER_IDLE;
        else if (scl_rise && cnt_next == count_last)
          xfer_next = XFER_IDLE;
      default:
        xfer_next = XFER_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      xfer_reg <= XFER_IDLE;
    else
      xfer_reg <= xfer_next;
  end

  // Bus state flags; cleared and held at zero outside bus mode
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      status_reg <= STATUS_RESET;
    else if (!i2c_mode_reg)
      status_reg <= STATUS_RESET;
    else
    begin
      if (start_evt)
        status_reg.bus_busy_flag <= 1'b1;
      else if (stop_evt)
        status_reg.bus_busy_flag <= 1'b0;
      if (start_evt)
        status_reg.start_seen_flag <= 1'b1;
      else if (scl_rise && cnt_next == COUNT_NINE)
        status_reg.start_seen_flag <= 1'b0;
      status_reg.count_nine_flag <= (cnt_next == COUNT_NINE);
      status_reg.count_eight_flag <= (cnt_next == COUNT_EIGHT);
    end
  end

  // The register is shown through a mode gate so a mode change reads zero at once
  assign status_view = i2c_mode_reg ? status_reg : STATUS_RESET;

  // Buffer load is honoured even mid transfer; software is expected not to do it
  assign load_shift = reg_wr && hit(reg_addr, ADDR_SHIFT_DATA);

  // Shift register: rising edge captures into the LSB
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      shift_reg <= SHIFT_RESET;
    else if (load_shift)
      shift_reg <= reg_wdata;
    else if (scl_rise)
      shift_reg <= {shift_reg[6:0], pins_s.sda};
  end

  // Outgoing bit follows the MSB at each falling edge while transmitting
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      sda_out_reg <= 1'b1;
    else if (load_shift)
      sda_out_reg <= reg_wdata[7];
    else if (scl_fall && transmit_reg && xfer_reg == XFER_ACTIVE)
      sda_out_reg <= shift_reg[7];
  end

  assign sda_out = sda_out_reg;
  assign sda_oe = transmit_reg && (xfer_reg == XFER_ACTIVE);

  // Interrupt events; sticky status, read clears but a new event wins
  assign irq_events[IRQ_START_BIT] = start_evt;
  assign irq_events[IRQ_STOP_BIT] = stop_evt;
  assign irq_events[IRQ_EIGHT_BIT] = scl_rise && cnt_next == COUNT_EIGHT;
  assign irq_events[IRQ_NINE_BIT] = scl_rise && cnt_next == COUNT_NINE;

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_stat_reg <= IRQ_RESET;
    else if (reg_rd && hit(reg_addr, ADDR_IRQ_STATUS))
      irq_stat_reg <= irq_events;
    else
      irq_stat_reg <= irq_stat_reg | irq_events;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_mask_reg <= IRQ_RESET;
    else if (reg_wr && hit(reg_addr, ADDR_IRQ_MASK))
      irq_mask_reg <= reg_wdata[3:0];
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read path; status detection has no write decode at all, the counter no address
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_reg <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_STATUS_DETECT: rdata_reg <= {4'h0, status_view};
        ADDR_CONTROL: rdata_reg <= {5'h00, (xfer_reg == XFER_ACTIVE), transmit_reg,
                                    i2c_mode_reg};
        ADDR_SHIFT_DATA: rdata_reg <= shift_reg;
        ADDR_IRQ_STATUS: rdata_reg <= {4'h0, irq_stat_reg};
        ADDR_IRQ_MASK: rdata_reg <= {4'h0, irq_mask_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
    else
      rdata_reg <= 8'h00;
  end

  assign reg_rdata = rdata_reg;

  // Checks next to the logic above
  a_status_serial_zero:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      !i2c_mode_reg |=> (status_reg == STATUS_RESET))
    else $error("status detection not zero in serial mode");

  a_busy_after_start:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      (i2c_mode_reg && start_evt) ##1 i2c_mode_reg |-> status_reg.bus_busy_flag)
    else $error("busy flag not set after start");

  a_busy_after_stop:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      (i2c_mode_reg && stop_evt && !start_evt) |=> !status_reg.bus_busy_flag)
    else $error("busy flag not cleared after stop");

  a_start_clear_nine:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      (i2c_mode_reg && scl_rise && cnt_reg == COUNT_EIGHT && !start_evt)
      |=> !status_reg.start_seen_flag && status_reg.count_nine_flag)
    else $error("start flag not cleared at count nine");

  a_count_step:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      (scl_rise && !start_evt && cnt_reg == 4'h3) |=> (cnt_reg == 4'h4))
    else $error("counter did not advance on rising edge");

  a_count_hold:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!scl_rise && !start_evt) |=> $stable(cnt_reg))
    else $error("counter moved without a rising edge");

  a_count_clear_start:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      start_evt |=> (cnt_reg == COUNT_START))
    else $error("counter not cleared by start");

  a_capture_lsb:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      (scl_rise && !load_shift) |=> shift_reg[0] == $past(pins_s.sda)
      && shift_reg[7:1] == $past(shift_reg[6:0]))
    else $error("serial data not captured into LSB");

  a_msb_drive:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      (scl_fall && transmit_reg && xfer_reg == XFER_ACTIVE && !load_shift)
      |=> sda_out == $past(shift_reg[7]))
    else $error("MSB not driven on falling edge");

  a_eight_flag:
    assert property (@(posedge ref_clk) disable iff (sys_rst)
      (i2c_mode_reg && scl_rise && !start_evt && cnt_reg == 4'h7) ##1 i2c_mode_reg
      |-> status_view.count_eight_flag)
    else $error("eight-count flag missing");

endmodule

// *** serial_peer.sv ***
`timescale 1ns/1ps
// Remote serial or two-wire peer: owns the clock pin and shares the data line
module serial_peer
  import serial0_pkg::*;
(
  input wire logic sda_out, // Block data level
  input wire logic sda_oe, // Block data enable
  output serial0_pkg::pins_type pins // Wire levels seen by the block
);
  logic scl_drv;
  logic sda_drv;

  // Wired line with pull-up: a released line reads high, not its last value
  assign pins = {scl_drv, sda_drv & ~(sda_oe & ~sda_out)};

  // Clock stands high between frames
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // One bit; sampled late in the high phase because the block answers a fall slowly
  // Wire changes sit mid-cycle of the block clock so the synchroniser never races them
  task automatic clock_bit(input logic b, output logic r);
    #50;
    scl_drv = 1'b0;
    sda_drv = b;
    #400;
    scl_drv = 1'b1;
    #300;
    r = pins.sda;
    #50;
  endtask

  // Eight bits, most significant first
  task automatic clock_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      clock_bit(tx[i], rx[i]);
    end
  endtask

  // Data falls while the clock is high
  task automatic start_cond();
    #50;
    sda_drv = 1'b1;
    #400;
    sda_drv = 1'b0;
    #350;
  endtask

  // Data rises while the clock is high; the clock rise before it is one more count
  task automatic stop_cond();
    #50;
    scl_drv = 1'b0;
    sda_drv = 1'b0;
    #400;
    scl_drv = 1'b1;
    #400;
    sda_drv = 1'b1;
    #350;
  endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("unexpected at %0t got %h expected %h", $time, got, exp); \
    end \
  end

module testbench;
  import serial0_pkg::*;
  logic ref_clk;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  pins_type pins;
  logic sda_out;
  logic sda_oe;
  logic irq;
  logic [7:0] v;
  logic [7:0] rx;
  logic b;
  int err_total;
  int samples_checked;

  // 10 MHz block clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  serial_clock_counter_and_shifter dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pins),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

  serial_peer peer (.sda_out(sda_out), .sda_oe(sda_oe), .pins(pins));

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // Step past the edge so a check right after sees the write's effect
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Pin edges reach the flags only after the synchroniser
  task automatic settle();
    repeat (6) @(posedge ref_clk);
  endtask

  // Bounded poll for the end of a transfer
  task automatic wait_idle();
    for (int i = 0; i < 20; i++)
    begin
      rd(ADDR_CONTROL, v);
      if (v[CTRL_WAIT_RELEASE_BIT] === 1'b0)
        break;
    end
    if (v[CTRL_WAIT_RELEASE_BIT] !== 1'b0)
    begin
      err_total++;
      test_done();
    end
  endtask

  task automatic t_reset();
    rd(ADDR_STATUS_DETECT, v);
    `CHK(v, 8'h00)
    wr(ADDR_STATUS_DETECT, 8'hff);
    rd(ADDR_STATUS_DETECT, v);
    `CHK(v, 8'h00)
    rd(8'h30, v);
    `CHK(v, 8'h00)
    rd(ADDR_IRQ_STATUS, v);
    `CHK(v, 8'h00)
    `CHK({irq, sda_oe}, 2'h0)
    wr(ADDR_CONTROL, 8'h04);
    rd(ADDR_CONTROL, v);
    `CHK(v, 8'h04)
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, v);
    `CHK(v, 8'h00)
  endtask

  // Buffer loaded before the transfer starts, never during it
  task automatic t_serial_tx();
    wr(ADDR_SHIFT_DATA, 8'h96);
    wr(ADDR_CONTROL, 8'h06);
    peer.clock_byte(8'hff, rx);
    `CHK(rx, 8'h96)
    wait_idle();
    rd(ADDR_STATUS_DETECT, v);
    `CHK(v, 8'h00)
  endtask

  task automatic t_serial_rx();
    wr(ADDR_CONTROL, 8'h04);
    peer.clock_byte(8'h3c, rx);
    wait_idle();
    rd(ADDR_SHIFT_DATA, v);
    `CHK(v, 8'h3c)
    peer.start_cond();
    settle();
    rd(ADDR_STATUS_DETECT, v);
    `CHK(v, 8'h00)
    peer.stop_cond();
  endtask

  // Two-wire frame: start, byte, ninth clock, wrap, stop, then interrupts
  task automatic t_i2c();
    rd(ADDR_IRQ_STATUS, v);
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_CONTROL, 8'h05);
    peer.start_cond();
    settle();
    rd(ADDR_STATUS_DETECT, v);
    `CHK(v, 8'h03)
    `CHK(irq, 1'b0)
    peer.clock_byte(8'ha6, rx);
    settle();
    rd(ADDR_STATUS_DETECT, v);
    `CHK(v, 8'h0b)
    peer.clock_bit(1'b1, b);
    settle();
    rd(ADDR_STATUS_DETECT, v);
    `CHK(v, 8'h05)
    peer.clock_bit(1'b1, b);
    settle();
    rd(ADDR_STATUS_DETECT, v);
    `CHK(v, 8'h01)
    peer.stop_cond();
    settle();
    rd(ADDR_STATUS_DETECT, v);
    `CHK(v, 8'h00)
    wr(ADDR_IRQ_MASK, 8'h0f);
    `CHK(irq, 1'b1)
    rd(ADDR_IRQ_STATUS, v);
    `CHK(v, 8'h0f)
    `CHK(irq, 1'b0)
    rd(ADDR_IRQ_STATUS, v);
    `CHK(v, 8'h00)
    rd(ADDR_IRQ_MASK, v);
    `CHK(v, 8'h0f)
  endtask

  // A hang counts as a mismatch
  initial
  begin
    #2000000;
    err_total++;
    test_done();
  end

  initial
  begin
    err_total = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_serial_tx();
    t_serial_rx();
    t_i2c();
    test_done();
  end
endmodule
